// *** jnp_pkg.sv ***
// Package for the net probe control block: constants, types, states.
// Assumes nothing outside; every user writes jnp_pkg::name.
package jnp_pkg;

    // ****************************************************************
    // Timing and sizing constants
    // ****************************************************************
    localparam int unsigned CLK_PERIOD_NS = 4;
    localparam int unsigned EXIT_TMS_HIGH_CYCLES = 5;
    localparam int unsigned SYNC_STAGES = 2;
    localparam int unsigned NET_SEL_W = 8;
    localparam int unsigned NET_COUNT = 256;
    localparam int unsigned SEL_BITS = 2 * NET_SEL_W;
    localparam logic [2:0] TMS_CNT_ONE = 3'h1;
    localparam logic [2:0] TMS_CNT_ZERO = 3'h0;
    localparam logic [NET_SEL_W-1:0] SEL_RESET = 8'h00;
    localparam logic [SEL_BITS-1:0] SHIFT_RESET = 16'h0000;

    // ****************************************************************
    // Types
    // ****************************************************************
    // Simplified TAP walk: only what probing needs to know
    typedef enum logic [1:0] {
        JNP_TLR,
        JNP_IDLE,
        JNP_SHIFT
    } jnp_tap_state_t;

    // Sampled test pins
    typedef struct packed {
        logic tck;
        logic tms;
        logic tdi;
    } jnp_pins_t;

    // Selected nets for the two probe outputs
    typedef struct packed {
        logic [NET_SEL_W-1:0] selA;
        logic [NET_SEL_W-1:0] selB;
    } jnp_sel_t;

endpackage

// *** jnp_sync.sv ***
// Two-stage synchroniser, one per bit of a bus.
// Assumes inputs come from outside the ref_clk domain.
module jnp_sync #(
    parameter int unsigned WIDTH = 1
) (
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic [WIDTH-1:0] asyncIn,
    output logic [WIDTH-1:0] syncOut
);

    logic [WIDTH-1:0] meta_q;

    // ****************************************************************
    // Synchroniser; first stage feeds only the second
    // ****************************************************************
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            meta_q <= '0;
            syncOut <= '0;
        end else begin
            meta_q <= asyncIn;
            syncOut <= meta_q;
        end
    end

endmodule

// *** jnp_probe_ctrl.sv ***
// Net probe control behind the boundary-scan pins: probe enable, pin
// ownership and net selection onto two probe outputs.
// Assumes test pins arrive asynchronously; nets come from the core.
// Behaviour
// RL1: Probe only in JTAG mode, reset high
// RL2: Reset low holds TLR, no probing
// RL3: Programmed security fuse always disables probing
// RL4: Active probing drives selected nets out
// RL5: Probing blocks user inputs on test pins
// RL6: Unreserved test reset acts as high
// RL7: Unassigned reverted pins stay tristated
// RL8: Controller selects nets via TMS/TCK/TDI/TDO
// RL9: Pin configuration applies only outside TLR
// RL10: Controller sets JTAG mode, reset high
// RL11: Designs avoid test pins as inputs
// RL12: Flexible mode: enter TMS low, exit five
// RL13: Dedicated mode reserves pins, enables pull-ups
// RL14: Selection held until reshift or reset
module jnp_probe_ctrl #(
    parameter int unsigned NETS = jnp_pkg::NET_COUNT
) (
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic tckPin,
    input wire logic tmsPin,
    input wire logic tdiPin,
    input wire logic trstPinN,
    input wire logic trstPinDriven,
    input wire logic trstReserved,
    input wire logic dedicatedMode,
    input wire logic securityFuse,
    input wire logic [NETS-1:0] internalNets,
    input wire logic userProbeAOut,
    input wire logic userProbeAOe,
    input wire logic userProbeBOut,
    input wire logic userProbeBOe,
    input wire logic userTdoOut,
    input wire logic userTdoOe,
    input wire logic userTdoAssigned,
    output logic probe_out_a,
    output logic probe_out_a_oe,
    output logic probe_out_b,
    output logic probe_out_b_oe,
    output logic tdoOut,
    output logic tdoOe,
    output logic tmsPullupEn,
    output logic tdiPullupEn,
    output logic trstPullupEn,
    output logic userInputsBlocked,
    output logic probeActive
);

    localparam int unsigned SW = jnp_pkg::SEL_BITS;
    localparam int unsigned NW = jnp_pkg::NET_SEL_W;

    jnp_pkg::jnp_pins_t pinsRaw;
    jnp_pkg::jnp_pins_t pinsSync;
    jnp_pkg::jnp_tap_state_t tap_q;
    jnp_pkg::jnp_sel_t sel_q;
    logic [SW-1:0] shift_q;
    logic [2:0] tmsHighCnt_q;
    logic tckPrev_q;
    logic tdo_q;
    logic probeA_q;
    logic probeB_q;
    logic tckRise;
    logic tckFall;
    logic trstHigh;
    logic outOfTlr;

    // ****************************************************************
    // Pin sampling and TCK edge finding
    // ****************************************************************
    assign pinsRaw = '{tck: tckPin, tms: tmsPin, tdi: tdiPin};

    jnp_sync #(
        .WIDTH($bits(jnp_pkg::jnp_pins_t))
    ) uSync (
        .ref_clk(ref_clk),
        .rst_n(rst_n),
        .asyncIn(pinsRaw),
        .syncOut(pinsSync)
    );

    // Previous synced TCK, for edge detection on the fabric clock
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            tckPrev_q <= 1'b0;
        end else begin
            tckPrev_q <= pinsSync.tck;
        end
    end

    assign tckRise = pinsSync.tck & ~tckPrev_q;
    assign tckFall = ~pinsSync.tck & tckPrev_q;

    // Undriven reset pin is pulled up; unreserved pin reads as high
    assign trstHigh = ~trstReserved | ~trstPinDriven | trstPinN; // [RL6]

    // ****************************************************************
    // TAP walk
    // ****************************************************************
    // Reset low forces TLR; TMS low on a rising TCK leaves it, five
    // rising edges with TMS high return to it.
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            tap_q <= jnp_pkg::JNP_TLR;
        end else if (!trstHigh) begin
            tap_q <= jnp_pkg::JNP_TLR; // [RL2]
        end else if (tckRise) begin
            case (tap_q)
                jnp_pkg::JNP_TLR: begin
                    if (!pinsSync.tms) begin
                        tap_q <= jnp_pkg::JNP_IDLE; // [RL12]
                    end
                end
                jnp_pkg::JNP_IDLE: begin
                    if (tmsHighCnt_q ==
                        3'(jnp_pkg::EXIT_TMS_HIGH_CYCLES - 1)
                        && pinsSync.tms) begin
                        tap_q <= jnp_pkg::JNP_TLR; // [RL12]
                    end else if (!pinsSync.tms) begin
                        tap_q <= jnp_pkg::JNP_SHIFT;
                    end
                end
                jnp_pkg::JNP_SHIFT: begin
                    if (pinsSync.tms) begin
                        tap_q <= jnp_pkg::JNP_IDLE;
                    end
                end
                default: tap_q <= jnp_pkg::JNP_TLR;
            endcase
        end
    end

    // Consecutive TMS-high count on rising TCK
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            tmsHighCnt_q <= jnp_pkg::TMS_CNT_ZERO;
        end else if (!trstHigh || tap_q == jnp_pkg::JNP_TLR) begin
            tmsHighCnt_q <= jnp_pkg::TMS_CNT_ZERO;
        end else if (tckRise) begin
            if (!pinsSync.tms) begin
                tmsHighCnt_q <= jnp_pkg::TMS_CNT_ZERO;
            end else if (tmsHighCnt_q !=
                         3'(jnp_pkg::EXIT_TMS_HIGH_CYCLES)) begin
                tmsHighCnt_q <= tmsHighCnt_q + jnp_pkg::TMS_CNT_ONE;
            end
        end
    end

    // ****************************************************************
    // Net selection shift register
    // ****************************************************************
    // Selection updates only on leaving shift; held otherwise and
    // cleared whenever the TAP returns to TLR.
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            shift_q <= jnp_pkg::SHIFT_RESET;
            sel_q <= '{selA: jnp_pkg::SEL_RESET,
                       selB: jnp_pkg::SEL_RESET};
        end else if (tap_q == jnp_pkg::JNP_TLR) begin
            shift_q <= jnp_pkg::SHIFT_RESET;
            sel_q <= '{selA: jnp_pkg::SEL_RESET,
                       selB: jnp_pkg::SEL_RESET}; // [RL14]
        end else if (tckRise && tap_q == jnp_pkg::JNP_SHIFT) begin
            shift_q <= {pinsSync.tdi, shift_q[SW-1:1]}; // [RL8]
            if (pinsSync.tms) begin
                sel_q <= {pinsSync.tdi, shift_q[SW-1:1]}; // [RL14]
            end
        end
    end

    // TDO changes on falling TCK, LSB first
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            tdo_q <= 1'b0;
        end else if (tckFall) begin
            tdo_q <= shift_q[0];
        end
    end

    // ****************************************************************
    // Probe enable and output registers
    // ****************************************************************
    assign outOfTlr = tap_q != jnp_pkg::JNP_TLR; // [RL9]
    // Fuse overrides trstHigh and outOfTlr; mode pins count only once out of TLR
    assign probeActive = ~securityFuse & trstHigh & outOfTlr; // [RL1] [RL3]

    // Nets registered once; the design's own paths are untouched
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            probeA_q <= 1'b0;
            probeB_q <= 1'b0;
        end else begin
            probeA_q <= internalNets[sel_q.selA]; // [RL4]
            probeB_q <= internalNets[sel_q.selB]; // [RL4]
        end
    end

    // ****************************************************************
    // Pin ownership
    // ****************************************************************
    // User pins keep the user drivers; unassigned ones have oe low
    assign probe_out_a = probeActive ? probeA_q : userProbeAOut; // [RL4]
    assign probe_out_a_oe = probeActive | userProbeAOe; // [RL7]
    assign probe_out_b = probeActive ? probeB_q : userProbeBOut; // [RL4]
    assign probe_out_b_oe = probeActive | userProbeBOe; // [RL7]
    // Dedicated mode never lends TDO to the user
    assign tdoOut = (outOfTlr || dedicatedMode) ? tdo_q : userTdoOut;
    assign tdoOe = (outOfTlr && !securityFuse) ? 1'b1 :
                   (!dedicatedMode && userTdoAssigned && userTdoOe); // [RL7]
    assign userInputsBlocked = probeActive | dedicatedMode; // [RL5] [RL13]
    assign tmsPullupEn = dedicatedMode; // [RL13]
    assign tdiPullupEn = dedicatedMode; // [RL13]
    assign trstPullupEn = trstReserved;

endmodule

// *** jnp_probe_ctrl_properties.sv ***
// Port assertions for the net probe control block.
// Assumes a bind from the bench top; one ref_clk domain.
module jnp_probe_ctrl_properties #(
    parameter int unsigned NETS = 256
) (
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic tckPin,
    input wire logic trstPinN,
    input wire logic trstPinDriven,
    input wire logic trstReserved,
    input wire logic dedicatedMode,
    input wire logic securityFuse,
    input wire logic userProbeAOut,
    input wire logic userProbeAOe,
    input wire logic probe_out_a,
    input wire logic probe_out_a_oe,
    input wire logic probe_out_b_oe,
    input wire logic tmsPullupEn,
    input wire logic tdiPullupEn,
    input wire logic userInputsBlocked,
    input wire logic probeActive
);
    // ********
    // Helpers
    // ********
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_n);
    // Unreserved or pulled-up test reset counts as high
    logic trstOk;
    assign trstOk = !trstReserved || !trstPinDriven || trstPinN;
    sequence s_live; probeActive && trstOk && !securityFuse; endsequence
    sequence s_quiet; $stable(tckPin) && trstOk && !securityFuse; endsequence
    // ********
    // Properties
    // ********
    property p_fuse; securityFuse |-> !probeActive; endproperty
    property p_trst; !trstOk |=> !probeActive; endproperty
    property p_rise; $rose(probeActive) |-> $past(trstOk); endproperty
    property p_oe; probeActive |-> probe_out_a_oe && probe_out_b_oe;
    endproperty
    property p_block; probeActive |-> userInputsBlocked; endproperty
    property p_user; !probeActive |->
        probe_out_a == userProbeAOut && probe_out_a_oe == userProbeAOe;
    endproperty
    property p_pull; tmsPullupEn == dedicatedMode &&
        tdiPullupEn == dedicatedMode; endproperty
    // Test clock quiet before and after: no synced edge can still be
    // pending, so only a new edge, reset or the fuse may end probing
    property p_stay; s_quiet [*4] ##0 s_live ##1 s_quiet [*4] |->
        probeActive; endproperty
    a_fuse: assert property (p_fuse) else $error("fuse probing");
    a_trst: assert property (p_trst) else $error("reset probing");
    a_rise: assert property (p_rise) else $error("early probe");
    a_oe: assert property (p_oe) else $error("probe not driven");
    a_block: assert property (p_block) else $error("not blocked");
    a_user: assert property (p_user) else $error("user pin lost");
    a_pull: assert property (p_pull) else $error("pull-up wrong");
    a_stay: assert property (p_stay) else $error("probe dropped");
endmodule

// *** jnp_dbg_host.sv ***
// Behavioural debug controller that drives the test pins.
// Assumes the bench calls its tasks; the test clock idles low.
module jnp_dbg_host (
    output logic tck,
    output logic tms,
    output logic tdi
);
    timeunit 1ns;
    timeprecision 1ps;
    // Mode select idles high, as its pull-up holds it; never drives probes
    initial begin
        tck = 1'b0;
        tms = 1'b1;
        tdi = 1'b0;
    end
    // One 160 ns test clock; released data flips so nothing stale shows
    task automatic step(input logic m, input logic d);
        tms = m;
        tdi = d;
        #80 tck = 1'b1;
        #80 tck = 1'b0;
        tdi = ~d;
    endtask
    // Enter shift, then 16 bits LSB first, last one with mode select high
    task automatic shift(input jnp_pkg::jnp_sel_t s);
        logic [15:0] d;
        d = s;
        step(1'b0, 1'b0);
        for (int i = 0; i < 15; i++) begin
            step(1'b0, d[i]);
        end
        step(1'b1, d[15]);
    endtask
    // Five high clocks hand the pins back
    task automatic leave();
        repeat (5) step(1'b1, 1'b0);
    endtask
endmodule

// *** tb.sv ***
// Self-checking bench for the net probe control block.
// Assumes package, design, host model and checker are compiled first.
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    // ********
    // Signals
    // ********
    logic ref_clk, rst_n, tck, tms, tdi, trstPinN, trstPinDriven;
    logic trstReserved, dedicatedMode, securityFuse, probeActive;
    logic uAO, uAE, uBO, uBE, uTO, uTE, uTA, probe_out_a, probe_out_b;
    logic tdoOut, tdoOe, trstPullupEn;
    logic [6:0] userBits;
    logic [255:0] internalNets;
    logic [3:0] cases [5] = '{4'h7, 4'h4, 4'h5, 4'h1, 4'hF};
    int num_errors = 0;
    int checks = 0;
    int seed = 32'h276B;
    jnp_pkg::jnp_sel_t sel;
    assign {uAO, uAE, uBO, uBE, uTO, uTE, uTA} = userBits;
    always #2 ref_clk = ~ref_clk;
    jnp_dbg_host u_jnp_dbg_host (.tck, .tms, .tdi);
    jnp_probe_ctrl #(.NETS(256)) u_jnp_probe_ctrl (.ref_clk, .rst_n,
        .tckPin(tck), .tmsPin(tms), .tdiPin(tdi), .trstPinN, .trstPinDriven,
        .trstReserved, .dedicatedMode, .securityFuse, .internalNets,
        .userProbeAOut(uAO), .userProbeAOe(uAE), .userProbeBOut(uBO),
        .userProbeBOe(uBE), .userTdoOut(uTO), .userTdoOe(uTE),
        .userTdoAssigned(uTA), .probe_out_a, .probe_out_a_oe(),
        .probe_out_b, .probe_out_b_oe(), .tdoOut, .tdoOe,
        .tmsPullupEn(), .tdiPullupEn(), .trstPullupEn,
        .userInputsBlocked(), .probeActive);
    // ********
    // Tasks
    // ********
    task automatic chk(input string name, input logic exp, input logic got);
        checks++;
        if (got !== exp) begin
            num_errors++;
            $display("[ERR] %s expected %b seen %b", name, exp, got);
        end
    endtask
    // Case bits: fuse, reset reserved, reset level, reset driven
    function automatic logic live(input logic [3:0] c);
        return !c[3] && (!c[2] || !c[0] || c[1]);
    endfunction
    function automatic logic net(input logic a);
        return internalNets[a ? sel.selA : sel.selB];
    endfunction
    // New levels at the falling edge; wait out the registered net path
    task automatic drive(input logic [3:0] c);
        @(negedge ref_clk);
        {securityFuse, trstReserved, trstPinN, trstPinDriven} = c;
        for (int i = 0; i < 8; i++) internalNets[i*32 +: 32] = $random(seed);
        userBits = 7'($random(seed));
        repeat (3) @(negedge ref_clk);
    endtask
    task automatic run(input logic [3:0] c);
        drive(c);
        u_jnp_dbg_host.step(1'b0, 1'b0);
        @(negedge ref_clk);
        chk("probeActive", live(c), probeActive);
        if (live(c)) begin
            sel = 16'($random(seed));
            u_jnp_dbg_host.shift(sel);
            drive(c);
            chk("probe_out_a", net(1'b1), probe_out_a);
            chk("probe_out_b", net(1'b0), probe_out_b);
            // Last falling test clock shows the first bit shifted in
            chk("tdoOut", sel.selB[0], tdoOut);
            chk("tdoOe", 1'b1, tdoOe);
        end
        u_jnp_dbg_host.leave();
        drive(c);
        chk("probeActive", 1'b0, probeActive);
        chk("probe_out_a", uAO, probe_out_a);
        chk("probe_out_b", uBO, probe_out_b);
        chk("tdoOe", !dedicatedMode && uTA && uTE, tdoOe);
        chk("trstPullupEn", trstReserved, trstPullupEn);
    endtask
    task automatic complete_run();
        $display("checks %0d num_errors %0d", checks, num_errors);
        if (num_errors == 0 && checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    // ********
    // Sequence
    // ********
    initial begin
        ref_clk = 1'b0;
        rst_n = 1'b0;
        {securityFuse, trstReserved, trstPinN, trstPinDriven} = 4'h7;
        dedicatedMode = 1'b0;
        internalNets = '0;
        userBits = 7'h00;
        repeat (20) @(posedge ref_clk);
        @(negedge ref_clk);
        rst_n = 1'b1;
        chk("probeActive", 1'b0, probeActive);
        for (int m = 0; m < 2; m++) begin
            dedicatedMode = m[0];
            foreach (cases[i]) run(cases[i]);
        end
        complete_run();
    end
    // Hang guard well beyond the longest expected run
    initial begin
        #100000;
        num_errors++;
        complete_run();
    end
endmodule
bind jnp_probe_ctrl jnp_probe_ctrl_properties #(.NETS(NETS)) u_props (
    .ref_clk, .rst_n, .tckPin, .trstPinN, .trstPinDriven, .trstReserved,
    .dedicatedMode, .securityFuse, .userProbeAOut, .userProbeAOe,
    .probe_out_a, .probe_out_a_oe, .probe_out_b_oe, .tmsPullupEn,
    .tdiPullupEn, .userInputsBlocked, .probeActive);
